// >>> scb_segmented_client_bus.sv
// segmented client bus of the 100G MAC: receive staging and transmit intake
`timescale 1ns/1ps

// Function
// - rx error high flags errored packet
// - rx error valid only with qualify and end
// - 4-bit empty count on final transfer
// - empty count valid only with qualify and end
// - errored qualified transfer forces empty[2:0] to 000
// - ready high accepts, low applies back-pressure
// - overflow raised when back-pressure ignored
// - underflow raised on mid-packet starvation
// - error blocks sent while underflow persists
// - tx data captured whenever qualify high
// - tx inputs ignored while qualify low
// - four segments, own data, qualify, start
// - rx qualify validates all segment signals
// - rx start/end mark first and last
// - tx error at end replaces word, FCS off
module scb_segmented_client_bus
	import scb_pkg::*;
#(
	parameter int NUM_SEG = scb_pkg::SCB_NUM_SEG,
	parameter int SEG_W = scb_pkg::SCB_SEG_W,
	parameter int MTY_W = scb_pkg::SCB_MTY_W
) (
	input wire logic clk,
	input wire logic arst_n,
	// receive side from the mac core
	input wire logic [NUM_SEG-1:0] mac_rx_valid,
	input wire logic [NUM_SEG-1:0][SEG_W-1:0] mac_rx_data,
	input wire logic [NUM_SEG-1:0] mac_rx_sop,
	input wire logic [NUM_SEG-1:0] mac_rx_eop,
	input wire logic [NUM_SEG-1:0] mac_rx_err,
	input wire logic [NUM_SEG-1:0][MTY_W-1:0] mac_rx_mty,
	// receive side toward user logic
	output logic [NUM_SEG-1:0] rx_ena,
	output logic [NUM_SEG-1:0][SEG_W-1:0] rx_data,
	output logic [NUM_SEG-1:0] rx_sop,
	output logic [NUM_SEG-1:0] rx_eop,
	output logic [NUM_SEG-1:0] rx_err,
	output logic [NUM_SEG-1:0][MTY_W-1:0] rx_mty,
	// transmit side from user logic
	input wire logic [NUM_SEG-1:0] tx_ena,
	input wire logic [NUM_SEG-1:0][SEG_W-1:0] tx_data,
	input wire logic [NUM_SEG-1:0] tx_sop,
	input wire logic [NUM_SEG-1:0] tx_eop,
	input wire logic [NUM_SEG-1:0] tx_err,
	input wire logic [NUM_SEG-1:0][MTY_W-1:0] tx_mty,
	output logic tx_rdy,
	output logic tx_ovf,
	output logic tx_unf,
	// synchronous reset of the transmit path
	input wire logic tx_path_reset,
	// transmit side toward the mac core
	input wire logic line_tx_ready,
	output logic [NUM_SEG-1:0] line_tx_valid,
	output logic [NUM_SEG-1:0][SEG_W-1:0] line_tx_data,
	output logic [NUM_SEG-1:0] line_tx_sop,
	output logic [NUM_SEG-1:0] line_tx_eop,
	output logic [NUM_SEG-1:0] line_tx_err_word,
	output logic [NUM_SEG-1:0][MTY_W-1:0] line_tx_mty,
	output logic line_tx_err_blk
);
	import scb_pkg::*;

	// the empty count must address every byte of a segment
	if (NUM_SEG < 1 || SEG_W < 16 || (1 << MTY_W) != SEG_W / 8 || MTY_W <= SCB_MTY_LOW_W) begin : g_bad_param
		$error("scb_segmented_client_bus: unsupported segment geometry");
	end

	// receive staging, one register stage per segment
	for (genvar i = 0; i < NUM_SEG; i++) begin : g_rx
		// markers drop to zero off qualify so stale values never leak
		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n) begin
				rx_ena[i] <= 1'b0;
				rx_data[i] <= '0;
				rx_sop[i] <= 1'b0;
				rx_eop[i] <= 1'b0;
				rx_err[i] <= 1'b0;
				rx_mty[i] <= '0;
			end else begin
				rx_ena[i] <= mac_rx_valid[i];
				if (mac_rx_valid[i]) begin
					rx_data[i] <= mac_rx_data[i];
					rx_sop[i] <= mac_rx_sop[i];
					rx_eop[i] <= mac_rx_eop[i];
					rx_err[i] <= mac_rx_eop[i] & mac_rx_err[i];
					if (!mac_rx_eop[i]) begin
						rx_mty[i] <= '0;
					end else if (mac_rx_err[i]) begin
						rx_mty[i] <= {mac_rx_mty[i][MTY_W-1:SCB_MTY_LOW_W], SCB_MTY_ERR_LOW};
					end else begin
						rx_mty[i] <= mac_rx_mty[i];
					end
				end else begin
					rx_sop[i] <= 1'b0;
					rx_eop[i] <= 1'b0;
					rx_err[i] <= 1'b0;
					rx_mty[i] <= '0;
				end
			end
		end

		property p_rx_err_follow;
			@(posedge clk) disable iff (!arst_n)
			mac_rx_valid[i] && mac_rx_eop[i] |=> rx_err[i] == $past(mac_rx_err[i]);
		endproperty
		a_rx_err_follow: assert property (p_rx_err_follow) else $error("rx error not carried");
		property p_rx_err_qual;
			@(posedge clk) disable iff (!arst_n)
			rx_err[i] |-> rx_ena[i] && rx_eop[i];
		endproperty
		a_rx_err_qual: assert property (p_rx_err_qual) else $error("rx error outside end transfer");
		property p_rx_mty_pass;
			@(posedge clk) disable iff (!arst_n)
			mac_rx_valid[i] && mac_rx_eop[i] && !mac_rx_err[i] |=> rx_mty[i] == $past(mac_rx_mty[i]);
		endproperty
		a_rx_mty_pass: assert property (p_rx_mty_pass) else $error("rx empty count lost");
		property p_rx_mty_err;
			@(posedge clk) disable iff (!arst_n)
			mac_rx_valid[i] && mac_rx_eop[i] && mac_rx_err[i] |=>
				rx_mty[i][SCB_MTY_LOW_W-1:0] == SCB_MTY_ERR_LOW &&
				rx_mty[i][MTY_W-1] == $past(mac_rx_mty[i][MTY_W-1]);
		endproperty
		a_rx_mty_err: assert property (p_rx_mty_err) else $error("rx empty low bits not forced");
		property p_rx_qual;
			@(posedge clk) disable iff (!arst_n)
			!mac_rx_valid[i] |=> !rx_ena[i] && !rx_sop[i] && !rx_eop[i] && rx_mty[i] == '0;
		endproperty
		a_rx_qual: assert property (p_rx_qual) else $error("rx markers without qualify");
	end

	// transmit packet tracking across segments in byte order
	scb_tx_state_t state;
	scb_tx_state_t next_state;
	logic pkt_bad;
	logic next_pkt_bad;
	logic [NUM_SEG:0] in_chain;
	logic [NUM_SEG:0] bad_chain;
	logic [NUM_SEG-1:0] err_eff;
	logic any_ena;
	logic starving;

	assign in_chain[0] = (state != SCB_IDLE);
	assign bad_chain[0] = pkt_bad;
	assign any_ena = |tx_ena;

	// segment i sees the packet state left by segments below it
	for (genvar i = 0; i < NUM_SEG; i++) begin : g_chain
		assign in_chain[i+1] = tx_ena[i] ? ((in_chain[i] | tx_sop[i]) & ~tx_eop[i]) : in_chain[i];
		assign bad_chain[i+1] = (tx_ena[i] & (tx_sop[i] | tx_eop[i])) ? 1'b0 : bad_chain[i];
		// a starved packet is closed with an error word like a user error
		assign err_eff[i] = tx_ena[i] & tx_eop[i] & (tx_err[i] | (bad_chain[i] & ~tx_sop[i]));
	end

	// only an empty cycle with ready high counts as starvation
	assign starving = in_chain[0] & ~any_ena;

	// next packet state
	always_comb begin
		next_state = state;
		next_pkt_bad = bad_chain[NUM_SEG] & in_chain[NUM_SEG];
		case (state)
			SCB_IDLE: begin
				if (in_chain[NUM_SEG]) begin
					next_state = SCB_PKT;
				end
			end
			SCB_PKT: begin
				if (starving && tx_rdy) begin
					next_state = SCB_STARVE;
					next_pkt_bad = 1'b1;
				end else if (!in_chain[NUM_SEG]) begin
					next_state = SCB_IDLE;
				end
			end
			SCB_STARVE: begin
				if (any_ena) begin
					next_state = in_chain[NUM_SEG] ? SCB_PKT : SCB_IDLE;
				end
			end
			default: begin
				next_state = SCB_IDLE;
				next_pkt_bad = 1'b0;
			end
		endcase
	end

	// packet state register, also cleared by the path reset
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= SCB_IDLE;
			pkt_bad <= 1'b0;
		end else if (tx_path_reset) begin
			state <= SCB_IDLE;
			pkt_bad <= 1'b0;
		end else begin
			state <= next_state;
			pkt_bad <= next_pkt_bad;
		end
	end

	// underflow flag and error block request follow the starve state
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_unf <= 1'b0;
			line_tx_err_blk <= 1'b0;
		end else if (tx_path_reset) begin
			tx_unf <= 1'b0;
			line_tx_err_blk <= 1'b0;
		end else begin
			tx_unf <= (next_state == SCB_STARVE);
			line_tx_err_blk <= (next_state == SCB_STARVE);
		end
	end

	// back-pressure and overflow
	logic [SCB_GRACE_W-1:0] low_cnt;
	logic violate;

	// transfers in the first four ready-low cycles are still absorbed
	assign violate = any_ena & ~tx_rdy & (low_cnt == SCB_GRACE_W'(SCB_GRACE_CYC));

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			low_cnt <= SCB_GRACE_ZERO;
		end else if (tx_rdy || tx_path_reset) begin
			low_cnt <= SCB_GRACE_ZERO;
		end else if (low_cnt != SCB_GRACE_W'(SCB_GRACE_CYC)) begin
			low_cnt <= low_cnt + SCB_GRACE_ONE;
		end
	end

	// overflow stays until the path is reset; ready stays low meanwhile
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_ovf <= 1'b0;
			tx_rdy <= 1'b0;
		end else if (tx_path_reset) begin
			tx_ovf <= 1'b0;
			tx_rdy <= 1'b0;
		end else begin
			tx_ovf <= tx_ovf | violate;
			tx_rdy <= line_tx_ready & ~tx_ovf & ~violate;
		end
	end

	// transmit capture, one register stage per segment
	for (genvar i = 0; i < NUM_SEG; i++) begin : g_tx
		// data holds when qualify is low so the core sees no glitch
		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n) begin
				line_tx_valid[i] <= 1'b0;
				line_tx_data[i] <= '0;
				line_tx_sop[i] <= 1'b0;
				line_tx_eop[i] <= 1'b0;
				line_tx_err_word[i] <= 1'b0;
				line_tx_mty[i] <= '0;
			end else begin
				line_tx_valid[i] <= tx_ena[i] & ~tx_path_reset;
				if (tx_ena[i]) begin
					line_tx_data[i] <= tx_data[i];
					line_tx_sop[i] <= tx_sop[i];
					line_tx_eop[i] <= tx_eop[i];
					line_tx_err_word[i] <= err_eff[i];
					if (!tx_eop[i]) begin
						line_tx_mty[i] <= '0;
					end else if (err_eff[i]) begin
						line_tx_mty[i] <= {tx_mty[i][MTY_W-1:SCB_MTY_LOW_W], SCB_MTY_ERR_LOW};
					end else begin
						line_tx_mty[i] <= tx_mty[i];
					end
				end else begin
					line_tx_sop[i] <= 1'b0;
					line_tx_eop[i] <= 1'b0;
					line_tx_err_word[i] <= 1'b0;
					line_tx_mty[i] <= '0;
				end
			end
		end

		property p_tx_capture;
			@(posedge clk) disable iff (!arst_n)
			tx_ena[i] && !tx_path_reset |=> line_tx_valid[i] && line_tx_data[i] == $past(tx_data[i]);
		endproperty
		a_tx_capture: assert property (p_tx_capture) else $error("tx data not captured");
		property p_tx_ignore;
			@(posedge clk) disable iff (!arst_n)
			!tx_ena[i] |=> !line_tx_valid[i] && !line_tx_err_word[i] && $stable(line_tx_data[i]);
		endproperty
		a_tx_ignore: assert property (p_tx_ignore) else $error("tx inputs used without qualify");
		property p_tx_err_word;
			@(posedge clk) disable iff (!arst_n)
			tx_ena[i] && tx_eop[i] && tx_err[i] |=>
				line_tx_err_word[i] && line_tx_mty[i][SCB_MTY_LOW_W-1:0] == SCB_MTY_ERR_LOW;
		endproperty
		a_tx_err_word: assert property (p_tx_err_word) else $error("tx error word missing");
	end

	property p_tx_rdy;
		@(posedge clk) disable iff (!arst_n)
		!line_tx_ready |=> !tx_rdy;
	endproperty
	a_tx_rdy: assert property (p_tx_rdy) else $error("ready high while core stalls");
	property p_tx_ovf;
		@(posedge clk) disable iff (!arst_n)
		(!tx_rdy && !tx_path_reset) [*5] ##0 (|tx_ena) |=> tx_ovf;
	endproperty
	a_tx_ovf: assert property (p_tx_ovf) else $error("overflow not flagged");

	property p_tx_ovf_hold;
		@(posedge clk) disable iff (!arst_n)
		tx_ovf && !tx_path_reset |=> tx_ovf && !tx_rdy;
	endproperty
	a_tx_ovf_hold: assert property (p_tx_ovf_hold) else $error("overflow cleared without reset");

	property p_tx_unf;
		@(posedge clk) disable iff (!arst_n)
		state == SCB_PKT && tx_rdy && !(|tx_ena) && !tx_path_reset |=>
			tx_unf ##1 (tx_unf || $past(|tx_ena) || $past(tx_path_reset));
	endproperty
	a_tx_unf: assert property (p_tx_unf) else $error("underflow not flagged");

	property p_tx_err_blk;
		@(posedge clk) disable iff (!arst_n)
		tx_unf |-> line_tx_err_blk && line_tx_valid == '0;
	endproperty
	a_tx_err_blk: assert property (p_tx_err_blk) else $error("no error block during underflow");
endmodule // scb_segmented_client_bus

// >>> scb_pkg.sv
// constants and types shared by the segmented client bus block
package scb_pkg;
	// bus geometry
	localparam int SCB_NUM_SEG = 4;
	localparam int SCB_SEG_W = 128;
	localparam int SCB_MTY_W = 4;
	// empty-count bits that read as zero on an errored last transfer
	localparam int SCB_MTY_LOW_W = 3;
	localparam logic [2:0] SCB_MTY_ERR_LOW = 3'h0;
	// cycles user logic may keep sending after ready falls
	localparam int SCB_GRACE_CYC = 4;
	localparam int SCB_GRACE_W = 3;
	localparam logic [2:0] SCB_GRACE_ZERO = 3'h0;
	localparam logic [2:0] SCB_GRACE_ONE = 3'h1;
	// transmit packet tracking
	typedef enum logic [2:0] {
		SCB_IDLE = 3'h1,
		SCB_PKT = 3'h2,
		SCB_STARVE = 3'h4
	} scb_tx_state_t;
endpackage

// >>> scb_user_model.sv
// user packet source on the segmented transmit bus
`timescale 1ns/1ps
module scb_user_model
	import scb_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic go,
	input wire logic [3:0] len,
	input wire logic bad,
	input wire logic gap,
	input wire logic ign,
	input wire logic tx_rdy,
	output logic busy,
	output logic [scb_pkg::SCB_NUM_SEG-1:0] tx_ena,
	output logic [scb_pkg::SCB_NUM_SEG-1:0][scb_pkg::SCB_SEG_W-1:0] tx_data,
	output logic [scb_pkg::SCB_NUM_SEG-1:0] tx_sop,
	output logic [scb_pkg::SCB_NUM_SEG-1:0] tx_eop,
	output logic [scb_pkg::SCB_NUM_SEG-1:0] tx_err,
	output logic [scb_pkg::SCB_NUM_SEG-1:0][scb_pkg::SCB_MTY_W-1:0] tx_mty
);
	logic [3:0] beat;
	logic gapped;
	logic last;
	assign last = beat == len - 4'h1;
	// one beat a cycle on all segments; ign breaks back-pressure on purpose
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			busy <= 1'b0;
			beat <= 4'h0;
			gapped <= 1'b0;
			tx_ena <= '0;
			tx_data <= '0;
			tx_sop <= '0;
			tx_eop <= '0;
			tx_err <= '0;
			tx_mty <= '0;
		end else if (busy && !(gap && beat == 4'h1 && !gapped) && (tx_rdy || ign)) begin
			tx_ena <= 4'hf;
			for (int s = 0; s < 4; s++) begin
				tx_data[s] <= {16{s[3:0], beat}};
			end
			tx_sop <= {3'h0, beat == 4'h0};
			tx_eop <= {last, 3'h0};
			tx_err <= {bad && last, 3'h0};
			tx_mty <= {last ? 4'hf : 4'h0, 12'h000};
			beat <= beat + 4'h1;
			busy <= !last;
		end else begin
			// idle lines flip so a stale value cannot pass for a good one
			tx_ena <= '0;
			tx_data <= ~tx_data;
			tx_sop <= ~tx_sop;
			tx_eop <= ~tx_eop;
			tx_err <= ~tx_err;
			tx_mty <= ~tx_mty;
			busy <= busy || go;
			if (go) begin
				beat <= 4'h0;
				gapped <= 1'b0;
			end else begin
				gapped <= gapped || (busy && gap && beat == 4'h1);
			end
		end
	end
endmodule // scb_user_model

// >>> scb_segmented_client_bus_tb.sv
// self-checking bench of the segmented client bus block
`timescale 1ns/1ps
module scb_segmented_client_bus_tb;
	import scb_pkg::*;
	logic clk, arst_n, tx_rdy, tx_ovf, tx_unf, tx_path_reset, line_tx_ready, line_tx_err_blk;
	logic go, bad, gap, ign, busy;
	logic [3:0] len, mac_rx_valid, mac_rx_sop, mac_rx_eop, mac_rx_err, rx_ena, rx_sop, rx_eop, rx_err;
	logic [3:0] tx_ena, tx_sop, tx_eop, tx_err, line_tx_valid, line_tx_sop, line_tx_eop, line_tx_err_word;
	logic [3:0][127:0] mac_rx_data, rx_data, tx_data, line_tx_data;
	logic [3:0][3:0] mac_rx_mty, rx_mty, tx_mty, line_tx_mty;
	int err_count, cmp_count, cyc;
	scb_segmented_client_bus i_dut (.clk(clk), .arst_n(arst_n), .mac_rx_valid(mac_rx_valid),
		.mac_rx_data(mac_rx_data), .mac_rx_sop(mac_rx_sop), .mac_rx_eop(mac_rx_eop), .mac_rx_err(mac_rx_err),
		.mac_rx_mty(mac_rx_mty), .rx_ena(rx_ena), .rx_data(rx_data), .rx_sop(rx_sop), .rx_eop(rx_eop),
		.rx_err(rx_err), .rx_mty(rx_mty), .tx_ena(tx_ena), .tx_data(tx_data), .tx_sop(tx_sop), .tx_eop(tx_eop),
		.tx_err(tx_err), .tx_mty(tx_mty), .tx_rdy(tx_rdy), .tx_ovf(tx_ovf), .tx_unf(tx_unf),
		.tx_path_reset(tx_path_reset), .line_tx_ready(line_tx_ready), .line_tx_valid(line_tx_valid),
		.line_tx_data(line_tx_data), .line_tx_sop(line_tx_sop), .line_tx_eop(line_tx_eop),
		.line_tx_err_word(line_tx_err_word), .line_tx_mty(line_tx_mty), .line_tx_err_blk(line_tx_err_blk));
	scb_user_model i_user (.clk(clk), .arst_n(arst_n), .go(go), .len(len), .bad(bad), .gap(gap), .ign(ign),
		.tx_rdy(tx_rdy), .busy(busy), .tx_ena(tx_ena), .tx_data(tx_data), .tx_sop(tx_sop), .tx_eop(tx_eop),
		.tx_err(tx_err), .tx_mty(tx_mty));
	// 100 MHz clock
	always #5 clk = ~clk;
	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		if (err_count == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// hang guard, well above the roughly 110 cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			report_and_stop();
		end
	end
	// segment 2 unqualified with live markers, segment 0 errored with full empty count
	task automatic t_rx();
		@(posedge clk);
		mac_rx_valid <= 4'hb;
		mac_rx_data <= {16{32'ha5a5_0f0f}};
		mac_rx_sop <= 4'hc;
		mac_rx_eop <= 4'h7;
		mac_rx_err <= 4'h5;
		mac_rx_mty <= 16'h0f5f;
		@(posedge clk);
		mac_rx_valid <= 4'h0;
		@(negedge clk);
		chk(rx_ena, 4'hb);
		chk(rx_sop, 4'h8);
		chk(rx_eop, 4'h3);
		chk(rx_err, 4'h1);
		chk(rx_mty, 16'h0058);
		chk(rx_data[3], {4{32'ha5a5_0f0f}});
		@(negedge clk);
		chk(rx_ena, 4'h0);
		chk(rx_err, 4'h0);
		chk(rx_mty, 16'h0000);
	endtask
	// one packet; g forces a one-cycle starvation after the first beat
	task automatic run_pkt(input logic [3:0] n, input logic b, input logic g);
		logic [3:0] k;
		logic [3:0] u;
		k = 4'h0;
		u = 4'h0;
		@(posedge clk);
		len <= n;
		bad <= b;
		gap <= g;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (20) begin
			@(negedge clk);
			// error blocks must track underflow in both directions
			if (tx_unf === 1'b1) begin
				u++;
				chk(line_tx_err_blk, 1'b1);
			end else begin
				chk({tx_unf, line_tx_err_blk}, 2'h0);
			end
			if (line_tx_valid === 4'hf && k < n) begin
				chk(line_tx_data[2], {16{4'h2, k}});
				chk(line_tx_sop, {3'h0, k == 4'h0});
				chk(line_tx_eop, {k == n - 4'h1, 3'h0});
				chk(line_tx_err_word, {k == n - 4'h1 && (b || g), 3'h0});
				chk(line_tx_mty[3], k != n - 4'h1 ? 4'h0 : (b || g) ? 4'h8 : 4'hf);
				k++;
			end else if (line_tx_valid === 4'h0) begin
				// the model flips idle lines, so stale markers would show here
				chk({line_tx_sop, line_tx_eop, line_tx_err_word, line_tx_mty}, 28'h000_0000);
			end
		end
		chk(k, n);
		chk(u, {3'h0, g});
		chk(line_tx_valid, 4'h0);
		chk(tx_ovf, 1'b0);
	endtask
	// back-pressure ignored for eight beats, then recovery by path reset
	task automatic t_ovf();
		@(posedge clk);
		line_tx_ready <= 1'b0;
		ign <= 1'b1;
		len <= 4'h8;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		@(negedge clk);
		chk(tx_rdy, 1'b0);
		repeat (16) @(posedge clk);
		line_tx_ready <= 1'b1;
		ign <= 1'b0;
		repeat (4) @(negedge clk);
		chk(tx_ovf, 1'b1);
		chk(tx_rdy, 1'b0);
		@(posedge clk);
		tx_path_reset <= 1'b1;
		@(posedge clk);
		tx_path_reset <= 1'b0;
		@(negedge clk);
		chk(tx_ovf, 1'b0);
		repeat (2) @(negedge clk);
		chk(tx_rdy, 1'b1);
	endtask
	initial begin
		clk = 1'b0;
		arst_n = 1'b0;
		{mac_rx_valid, mac_rx_sop, mac_rx_eop, mac_rx_err, go, bad, gap, ign, tx_path_reset} = '0;
		mac_rx_data = '0;
		mac_rx_mty = '0;
		len = 4'h1;
		line_tx_ready = 1'b1;
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		repeat (2) @(negedge clk);
		chk(tx_rdy, 1'b1);
		t_rx();
		run_pkt(4'h2, 1'b0, 1'b0);
		run_pkt(4'h2, 1'b1, 1'b0);
		run_pkt(4'h3, 1'b0, 1'b1);
		t_ovf();
		report_and_stop();
	end
endmodule // scb_segmented_client_bus_tb
